// *** logic/tchi_consts.svh ***
// Holds the widths, field positions, event counter preset and timing count of the tape control port.
// Assumes host word bit n sits at vector index 17-n, so host bit 17 is the LSB.
`ifndef TCHI_CONSTS_SVH
`define TCHI_CONSTS_SVH

// ------------------------------------------------------------------
// Widths and timing
// ------------------------------------------------------------------
`define TCHI_WORD_W       18
`define TCHI_CLK_MHZ      40
`define TCHI_TM_PERIOD_US 200
`define TCHI_TM_CYCLES    (`TCHI_TM_PERIOD_US * `TCHI_CLK_MHZ)
`define TCHI_TM_W         13
`define TCHI_EK_PRESET    3'h0

// ------------------------------------------------------------------
// Host word fields (vector indices)
// ------------------------------------------------------------------
`define TCHI_SEL_HI     15
`define TCHI_SEL_LO     12
`define TCHI_LC_GO      5
`define TCHI_LC_REV     4
`define TCHI_LC_SPARE   3
`define TCHI_LC_MODE_HI 2
`define TCHI_LC_MODE_LO 0
`define TCHI_ST_HI      17
`define TCHI_ST_LO      9

// ------------------------------------------------------------------
// Synchronised control inputs (vector indices)
// ------------------------------------------------------------------
`define TCHI_NCTL       17
`define TCHI_I_FLT      0
`define TCHI_I_SLP      1
`define TCHI_I_WRD      2
`define TCHI_I_WWR      3
`define TCHI_I_RST      4
`define TCHI_I_PCLR     5
`define TCHI_I_RUN      6
`define TCHI_I_MB12     7
`define TCHI_I_TWSW     8
`define TCHI_I_ENDZ     9
`define TCHI_I_MKERR    10
`define TCHI_I_TMERR    11
`define TCHI_I_WALLOW   12
`define TCHI_I_ONEUNIT  13
`define TCHI_I_BLKNUM   14
`define TCHI_I_WSLOT    15
`define TCHI_I_CSLOT    16

`endif

// *** logic/tchi_pkg.sv ***
// Types shared by the tape control host port.
// Assumes tchi_consts.svh is on the include path.
`include "tchi_consts.svh"

package tchi_pkg;

  typedef logic [`TCHI_WORD_W-1:0] tchi_word_t;

  typedef enum logic [2:0] {
    TCHI_MOVE     = 3'h0,
    TCHI_SEARCH   = 3'h1,
    TCHI_READ     = 3'h2,
    TCHI_WRITE    = 3'h3,
    TCHI_SPARE    = 3'h4,
    TCHI_READ_ALL = 3'h5,
    TCHI_WRT_ALL  = 3'h6,
    TCHI_WRT_TM   = 3'h7
  } tchi_mode_t;

  typedef struct packed {
    tchi_word_t           dbuf;
    tchi_word_t           out;
    logic [3:0]           unit;
    tchi_mode_t           mode;
    logic                 go;
    logic                 rev;
    logic                 spare;
    logic                 dflag;
    logic                 bflag;
    logic                 eflag;
    logic                 endz;
    logic                 miss;
    logic                 track_error_status;
    logic                 unable;
    logic                 wen;
    logic                 skip;
    logic [2:0]           ek;
    logic [`TCHI_TM_W-1:0] tm_cnt;
  } tchi_state_t;

endpackage : tchi_pkg

// *** logic/tchi_sync.sv ***
// Two-flop synchroniser with a rising-edge flag for a group of pins.
// Assumes each pin is quasi-static or holds for several clock periods.
`timescale 1ns/1ps

module tchi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tchi_sync_st_t;

  tchi_sync_st_t st_q;
  tchi_sync_st_t st_d;

  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // The first stage feeds only the second; edges are taken after it.
  assign lvl  = st_q.s2;
  assign rise = st_q.s2 & ~st_q.s3;

endmodule : tchi_sync

// *** logic/tchi_top.sv ***
// Host side of the word-by-word tape control: command decode, flags, status and data buffer.
// Assumes host pulses last many clock periods and host data is steady before each pulse.
`timescale 1ns/1ps
`include "tchi_consts.svh"

module tchi_top #(
  parameter int unsigned TM_CYCLES = `TCHI_TM_CYCLES
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              FLAG_TEST_PULSE,
  input  wire logic              SELECT_LOAD_PULSE,
  input  wire logic              WORD_READ_CMD,
  input  wire logic              WORD_WRITE_CMD,
  input  wire logic              READ_STATUS_CMD,
  input  wire logic              POWER_CLEAR,
  input  wire logic              RUN,
  input  wire logic              MEMBUF_BIT_TWELVE,
  input  wire tchi_pkg::tchi_word_t HOST_TO_CONTROL_LINES,
  input  wire logic              TRACK_WRITE_SWITCH,
  input  wire logic              END_ZONE_SEEN,
  input  wire logic              MARK_TRACK_FAULT,
  input  wire logic              TIMING_TRACK_FAULT,
  input  wire logic              WRITE_ALLOWED,
  input  wire logic              ONE_UNIT_SELECTED,
  input  wire logic              BLOCK_NUMBER_READY,
  input  wire logic              WORD_SLOT,
  input  wire logic              CHECKSUM_SLOT,
  input  wire tchi_pkg::tchi_word_t TAPE_WORD_IN,
  output tchi_pkg::tchi_word_t   CONTROL_TO_HOST_LINES,
  output tchi_pkg::tchi_word_t   TAPE_WORD_OUT,
  output logic                   SKIP,
  output logic                   DATA_FLAG,
  output logic                   BLOCK_FLAG,
  output logic                   ERROR_FLAG,
  output logic                   END_STATUS,
  output logic                   MISS_TIMING,
  output logic                   REVERSE,
  output logic                   GO,
  output logic                   TRACK_ERROR_STATUS,
  output logic                   UNABLE,
  output logic                   WRITE_ENABLE,
  output logic [3:0]             UNIT_SELECT,
  output tchi_pkg::tchi_mode_t   MODE,
  output logic [2:0]             EVENT_SEQUENCE_COUNTER
);

  import tchi_pkg::*;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [`TCHI_NCTL-1:0]     ctl_raw;
  logic [`TCHI_NCTL-1:0]     ctl_lvl;
  logic [`TCHI_NCTL-1:0]     ctl_rise;
  logic [2*`TCHI_WORD_W-1:0] wrd_lvl;
  tchi_word_t                host_w;
  tchi_word_t                tape_w;

  assign ctl_raw = {CHECKSUM_SLOT, WORD_SLOT, BLOCK_NUMBER_READY,
                    ONE_UNIT_SELECTED, WRITE_ALLOWED, TIMING_TRACK_FAULT,
                    MARK_TRACK_FAULT, END_ZONE_SEEN, TRACK_WRITE_SWITCH,
                    MEMBUF_BIT_TWELVE, RUN, POWER_CLEAR, READ_STATUS_CMD,
                    WORD_WRITE_CMD, WORD_READ_CMD, SELECT_LOAD_PULSE,
                    FLAG_TEST_PULSE};

  tchi_sync #(
    .W     (`TCHI_NCTL)
  ) u_sync_ctl (
    .clk   (CLK),
    .rst_n (RST_N),
    .din   (ctl_raw),
    .lvl   (ctl_lvl),
    .rise  (ctl_rise)
  );

  // Data words are steady well before their strobe, so each bit is
  // synchronised on its own without risk of a torn word.
  tchi_sync #(
    .W     (2*`TCHI_WORD_W)
  ) u_sync_wrd (
    .clk   (CLK),
    .rst_n (RST_N),
    .din   ({HOST_TO_CONTROL_LINES, TAPE_WORD_IN}),
    .lvl   (wrd_lvl),
    .rise  ()
  );

  assign host_w = wrd_lvl[2*`TCHI_WORD_W-1:`TCHI_WORD_W];
  assign tape_w = wrd_lvl[`TCHI_WORD_W-1:0];

  // ------------------------------------------------------------------
  // Decoded events
  // ------------------------------------------------------------------
  logic flt;
  logic slp;
  logic mb12;
  logic pclr;
  logic run_l;
  logic rd_cmd;
  logic wr_cmd;
  logic rs_cmd;
  logic sel_cmd;
  logic lc_cmd;
  logic d_event;
  logic b_event;
  logic tm_tick;
  logic rw_mode;
  logic rd_mode;
  logic wr_mode;

  assign flt    = ctl_rise[`TCHI_I_FLT];
  assign slp    = ctl_rise[`TCHI_I_SLP];
  assign mb12   = ctl_lvl[`TCHI_I_MB12];
  assign pclr   = ctl_rise[`TCHI_I_PCLR];
  assign run_l  = ctl_lvl[`TCHI_I_RUN];
  assign rd_cmd = ctl_rise[`TCHI_I_WRD];
  assign wr_cmd = ctl_rise[`TCHI_I_WWR];
  assign rs_cmd = ctl_rise[`TCHI_I_RST];

  assign sel_cmd = slp & ~mb12;
  assign lc_cmd  = slp & mb12;

  tchi_state_t s_q;
  tchi_state_t s_d;

  assign rd_mode = (s_q.mode == TCHI_READ) | (s_q.mode == TCHI_READ_ALL);
  assign wr_mode = (s_q.mode == TCHI_WRITE) | (s_q.mode == TCHI_WRT_ALL)
                 | (s_q.mode == TCHI_WRT_TM);
  assign rw_mode = rd_mode | (s_q.mode == TCHI_WRITE) | (s_q.mode == TCHI_WRT_ALL);

  // The track timing clock only runs with the switch on, and only in
  // write timing/mark mode does it ask the host for words.
  assign tm_tick = ctl_lvl[`TCHI_I_TWSW]
                 & (s_q.tm_cnt == `TCHI_TM_W'(TM_CYCLES - 1));

  assign d_event = s_q.go & (
      (ctl_rise[`TCHI_I_BLKNUM] & (s_q.mode == TCHI_SEARCH))
    | (ctl_rise[`TCHI_I_WSLOT] & rw_mode)
    | (tm_tick & (s_q.mode == TCHI_WRT_TM)));
  assign b_event = s_q.go & ctl_rise[`TCHI_I_CSLOT] & rw_mode;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.skip = 1'b0;

    if (ctl_lvl[`TCHI_I_TWSW]) begin
      if (tm_tick) begin
        s_d.tm_cnt = '0;
      end else begin
        s_d.tm_cnt = s_q.tm_cnt + `TCHI_TM_W'(1);
      end
    end else begin
      s_d.tm_cnt = '0;
    end

    if (flt) begin
      if (mb12) begin
        s_d.skip = s_q.eflag;
      end else begin
        s_d.skip = s_q.dflag;
      end
    end

    if (sel_cmd) begin
      s_d.unit = host_w[`TCHI_SEL_HI:`TCHI_SEL_LO];
    end

    // A new load control also clears the sticky error state; an error
    // raised in the same cycle below still wins.
    if (lc_cmd) begin
      s_d.go     = host_w[`TCHI_LC_GO];
      s_d.rev    = host_w[`TCHI_LC_REV];
      s_d.spare  = host_w[`TCHI_LC_SPARE];
      s_d.mode   = tchi_mode_t'(host_w[`TCHI_LC_MODE_HI:`TCHI_LC_MODE_LO]);
      s_d.endz   = 1'b0;
      s_d.miss   = 1'b0;
      s_d.track_error_status    = 1'b0;
      s_d.unable = 1'b0;
    end

    if (rd_cmd) begin
      s_d.out   = s_q.dbuf;
      s_d.dflag = 1'b0;
      s_d.bflag = 1'b0;
    end

    if (wr_cmd) begin
      s_d.dbuf  = host_w;
      s_d.dflag = 1'b0;
      s_d.bflag = 1'b0;
    end

    if (rs_cmd) begin
      s_d.out = '0;
      s_d.out[`TCHI_ST_HI:`TCHI_ST_LO] = {s_q.dflag, s_q.bflag, s_q.eflag,
                                          s_q.endz, s_q.miss, s_q.rev,
                                          s_q.go, s_q.track_error_status, s_q.unable};
    end

    // Flag sets come after the read and write clears so an event in their cycle
    // is kept; a power clear, applied after the sets, still drops it.
    if (d_event) begin
      if (s_q.dflag) begin
        s_d.miss = 1'b1;
      end
      s_d.dflag = 1'b1;
      if (rd_mode | (s_q.mode == TCHI_SEARCH)) begin
        s_d.dbuf = tape_w;
      end
      s_d.ek = s_q.ek + 3'h1;
    end

    if (b_event) begin
      if (s_q.bflag) begin
        s_d.miss = 1'b1;
      end
      s_d.bflag = 1'b1;
      if (rd_mode) begin
        s_d.dbuf = tape_w;
      end
      s_d.ek = `TCHI_EK_PRESET;
    end

    if (ctl_lvl[`TCHI_I_MKERR] | ctl_lvl[`TCHI_I_TMERR]) begin
      s_d.track_error_status = 1'b1;
    end

    if (s_q.go & ((wr_mode & ~ctl_lvl[`TCHI_I_WALLOW])
                  | ~ctl_lvl[`TCHI_I_ONEUNIT])) begin
      s_d.unable = 1'b1;
    end

    if (ctl_rise[`TCHI_I_ENDZ]) begin
      s_d.endz = 1'b1;
      s_d.go   = 1'b0;
    end

    if (!run_l) begin
      s_d.go = 1'b0;
    end

    if (pclr) begin
      s_d.unit   = '0;
      s_d.go     = 1'b0;
      s_d.rev    = 1'b0;
      s_d.spare  = 1'b0;
      s_d.mode   = TCHI_MOVE;
      s_d.endz   = 1'b0;
      s_d.miss   = 1'b0;
      s_d.track_error_status    = 1'b0;
      s_d.unable = 1'b0;
      s_d.dflag  = 1'b0;
      s_d.bflag  = 1'b0;
      s_d.ek     = `TCHI_EK_PRESET;
    end

    s_d.eflag = s_d.endz | s_d.miss | s_d.track_error_status | s_d.unable;
    s_d.wen   = s_d.go & wr_mode & ~s_d.eflag & ~pclr;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign CONTROL_TO_HOST_LINES  = s_q.out;
  assign TAPE_WORD_OUT          = s_q.dbuf;
  assign SKIP                   = s_q.skip;
  assign DATA_FLAG              = s_q.dflag;
  assign BLOCK_FLAG             = s_q.bflag;
  assign ERROR_FLAG             = s_q.eflag;
  assign END_STATUS             = s_q.endz;
  assign MISS_TIMING            = s_q.miss;
  assign REVERSE                = s_q.rev;
  assign GO                     = s_q.go;
  assign TRACK_ERROR_STATUS     = s_q.track_error_status;
  assign UNABLE                 = s_q.unable;
  assign WRITE_ENABLE           = s_q.wen;
  assign UNIT_SELECT            = s_q.unit;
  assign MODE                   = s_q.mode;
  assign EVENT_SEQUENCE_COUNTER = s_q.ek;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_data_test;
    flt && !mb12;
  endsequence

  sequence s_err_test;
    flt && mb12;
  endsequence

  sequence s_second_data;
    s_q.dflag && d_event && !pclr;
  endsequence

  a_skip_data: assert property (s_data_test |=> SKIP == $past(s_q.dflag))
    else $error("skip does not follow the data flag");

  a_skip_error: assert property (s_err_test |=> SKIP == $past(s_q.eflag))
    else $error("skip does not follow the error flag");

  a_power_clear: assert property (pclr |=> !GO && !DATA_FLAG && !BLOCK_FLAG
      && !ERROR_FLAG && !WRITE_ENABLE && EVENT_SEQUENCE_COUNTER == `TCHI_EK_PRESET)
    else $error("power clear left state behind");

  a_run_stop: assert property (!run_l |=> !GO)
    else $error("go stayed set with run low");

  a_end_halt: assert property (ctl_rise[`TCHI_I_ENDZ] && !pclr |=> END_STATUS && !GO)
    else $error("end zone did not halt motion");

  a_error_sum: assert property (ERROR_FLAG == (END_STATUS || MISS_TIMING
      || TRACK_ERROR_STATUS || UNABLE))
    else $error("error flag differs from its causes");

  a_wen_block: assert property (ERROR_FLAG |-> !WRITE_ENABLE)
    else $error("write enabled during an error");

  a_miss_set: assert property (s_second_data |=> MISS_TIMING ##1
      (MISS_TIMING || $past(lc_cmd) || $past(pclr)))
    else $error("second data flag did not set missed timing");

  a_status_word: assert property (rs_cmd |=>
      CONTROL_TO_HOST_LINES[`TCHI_ST_HI:`TCHI_ST_LO] == $past({s_q.dflag, s_q.bflag,
      s_q.eflag, s_q.endz, s_q.miss, s_q.rev, s_q.go, s_q.track_error_status, s_q.unable})
      && CONTROL_TO_HOST_LINES[`TCHI_ST_LO-1:0] == '0)
    else $error("status word wrong");

  a_flag_clear: assert property (rd_cmd && !d_event |=> !DATA_FLAG)
    else $error("word read did not clear the data flag");

  a_load_ctl: assert property (lc_cmd && !pclr && run_l && !ctl_rise[`TCHI_I_ENDZ]
      |=> GO == $past(host_w[`TCHI_LC_GO]) && REVERSE == $past(host_w[`TCHI_LC_REV]))
    else $error("load control fields not taken");

endmodule : tchi_top

// *** sim/tchi_host_model.sv ***
// Host processor model: transfer command pulses, bit twelve, run level and data lines.
// Assumes tchi_pkg is compiled first and a skip answer comes within eight cycles of a pulse.
`timescale 1ns/1ps

module tchi_host_model (
  input  wire logic            clk,
  input  wire logic            skip,
  output tchi_pkg::tchi_word_t host_lines,
  output logic [5:0]           pulses,
  output logic                 bit_twelve,
  output logic                 run
);
  import tchi_pkg::*;

  initial begin
    host_lines = 18'h00000;
    pulses     = 6'h00;
    bit_twelve = 1'b0;
    run        = 1'b1;
  end

  // Lines settle two cycles before the pulse and are inverted once their hold has run out,
  // so a control that samples late reads a wrong word instead of a lucky stale one.
  task automatic issue(input int idx, input logic b12, input tchi_word_t w, output logic seen);
    seen = 1'b0;
    @(posedge clk);
    host_lines <= w;
    bit_twelve <= b12;
    repeat (2) @(posedge clk);
    pulses[idx] <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      seen = seen | (skip === 1'b1);
      if (i == 3) begin
        pulses[idx] <= 1'b0;
      end
      if (i == 4) begin
        host_lines <= ~w;
        bit_twelve <= ~b12;
      end
    end
  endtask : issue

  task automatic set_run(input logic v);
    @(posedge clk);
    run <= v;
  endtask : set_run

endmodule : tchi_host_model

// *** sim/tb_top.sv ***
// Self-checking bench for the tape control host port, one task per scenario.
// Assumes the design files and the host model are compiled ahead of this file.
`timescale 1ns/1ps

module tb_top;
  import tchi_pkg::*;

  localparam int FLT = 0;
  localparam int SLP = 1;
  localparam int WRD = 2;
  localparam int WWR = 3;
  localparam int STS = 4;
  localparam int PCL = 5;

  logic       clk, rst_n, track_sw, mkf, tmf, wall, one_u, seen;
  logic       b12, run, skip, dflag, bflag, eflag, endst, miss, rev, go, trk, unab, wen;
  logic [3:0] ev;
  logic [5:0] pls;
  logic [3:0] unit;
  logic [2:0] ek;
  tchi_mode_t mode;
  tchi_word_t tape_in, tape_out, c2h, h2c;
  int         n_errors = 0;
  int         n_compared = 0;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  tchi_host_model host (.clk(clk), .skip(skip), .host_lines(h2c), .pulses(pls),
                        .bit_twelve(b12), .run(run));

  tchi_top #(.TM_CYCLES(16)) dut (
    .CLK(clk), .RST_N(rst_n), .FLAG_TEST_PULSE(pls[0]), .SELECT_LOAD_PULSE(pls[1]),
    .WORD_READ_CMD(pls[2]), .WORD_WRITE_CMD(pls[3]), .READ_STATUS_CMD(pls[4]),
    .POWER_CLEAR(pls[5]), .RUN(run), .MEMBUF_BIT_TWELVE(b12), .HOST_TO_CONTROL_LINES(h2c),
    .TRACK_WRITE_SWITCH(track_sw), .END_ZONE_SEEN(ev[0]), .MARK_TRACK_FAULT(mkf),
    .TIMING_TRACK_FAULT(tmf), .WRITE_ALLOWED(wall), .ONE_UNIT_SELECTED(one_u),
    .BLOCK_NUMBER_READY(ev[3]), .WORD_SLOT(ev[1]), .CHECKSUM_SLOT(ev[2]),
    .TAPE_WORD_IN(tape_in), .CONTROL_TO_HOST_LINES(c2h), .TAPE_WORD_OUT(tape_out),
    .SKIP(skip), .DATA_FLAG(dflag), .BLOCK_FLAG(bflag), .ERROR_FLAG(eflag),
    .END_STATUS(endst), .MISS_TIMING(miss), .REVERSE(rev), .GO(go),
    .TRACK_ERROR_STATUS(trk), .UNABLE(unab), .WRITE_ENABLE(wen), .UNIT_SELECT(unit),
    .MODE(mode), .EVENT_SEQUENCE_COUNTER(ek)
  );

  // Wide enough for every packed group of flags and words that a scenario compares.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The extra nanosecond lets the edge's register updates land before anything is read.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic cmd(input int idx, input logic b, input tchi_word_t w);
    host.issue(idx, b, w, seen);
    #1;
  endtask : cmd

  task automatic tape_ev(input int idx);
    @(posedge clk);
    ev[idx] <= 1'b1;
    repeat (4) @(posedge clk);
    ev[idx] <= 1'b0;
    wait_cyc(5);
  endtask : tape_ev

  function automatic tchi_word_t lc(input logic g, input logic r, input tchi_mode_t m);
    return {12'h000, g, r, 1'b0, m};
  endfunction : lc

  task automatic t_reset;
    chk({dflag, bflag, eflag, endst, miss, rev, go, trk, unab, wen, skip, ek, mode}, 18'h0);
    cmd(STS, 1'b0, 18'h3FFFF);
    chk(c2h, 18'h00000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_select_load;
    cmd(SLP, 1'b0, {2'h0, 4'hA, 12'h000});
    chk({unit, go, mode}, {12'h000, 4'hA, 1'b0, 3'h0});
    for (int m = 0; m < 8; m++) begin
      cmd(SLP, 1'b1, lc(1'b0, m[0], tchi_mode_t'(m[2:0])));
      chk({unit, rev, mode}, {10'h000, 4'hA, m[0], m[2:0]});
    end
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_SEARCH));
    chk(go, 1'b1);
    $display("test select_load done");
  endtask : t_select_load

  task automatic t_search;
    cmd(FLT, 1'b1, 18'h00000);
    chk(seen, 1'b0);
    cmd(FLT, 1'b0, 18'h00000);
    chk(seen, 1'b0);
    @(posedge clk);
    tape_in <= 18'h2AB5C;
    tape_ev(3);
    chk({dflag, tape_out}, {1'b1, 18'h2AB5C});
    cmd(FLT, 1'b0, 18'h00000);
    chk(seen, 1'b1);
    cmd(WRD, 1'b0, 18'h00000);
    chk(c2h, 18'h2AB5C);
    chk(dflag, 1'b0);
    $display("test search done");
  endtask : t_search

  task automatic t_read_word;
    cmd(SLP, 1'b1, lc(1'b1, 1'b1, TCHI_READ));
    @(posedge clk);
    tape_in <= 18'h1F00F;
    tape_ev(1);
    chk({dflag, miss, tape_out}, {2'h2, 18'h1F00F});
    tape_ev(1);
    chk({miss, eflag}, 18'h00003);
    tape_ev(2);
    chk(bflag, 1'b1);
    cmd(FLT, 1'b1, 18'h00000);
    chk(seen, 1'b1);
    cmd(STS, 1'b0, 18'h3FFFF);
    chk(c2h, {9'h1DC, 9'h000});
    cmd(WWR, 1'b0, 18'h15A5A);
    chk(tape_out, 18'h15A5A);
    chk({dflag, bflag}, 18'h00000);
    cmd(FLT, 1'b0, 18'h00000);
    chk(seen, 1'b0);
    $display("test read_word done");
  endtask : t_read_word

  task automatic t_unable;
    @(posedge clk);
    wall <= 1'b0;
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_WRITE));
    chk({unab, eflag, wen}, 18'h00006);
    @(posedge clk);
    wall  <= 1'b1;
    one_u <= 1'b0;
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_WRITE));
    chk(unab, 1'b1);
    @(posedge clk);
    one_u <= 1'b1;
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_WRITE));
    chk({unab, eflag, wen}, 18'h00001);
    @(posedge clk);
    mkf <= 1'b1;
    wait_cyc(6);
    chk({trk, eflag, wen}, 18'h00006);
    @(posedge clk);
    mkf <= 1'b0;
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_MOVE));
    @(posedge clk);
    tmf <= 1'b1;
    wait_cyc(6);
    chk(trk, 1'b1);
    @(posedge clk);
    tmf <= 1'b0;
    $display("test unable done");
  endtask : t_unable

  task automatic t_end_run;
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_MOVE));
    tape_ev(0);
    chk({endst, go, eflag}, 18'h00005);
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_MOVE));
    host.set_run(1'b0);
    wait_cyc(6);
    chk({go, endst}, 18'h00000);
    host.set_run(1'b1);
    $display("test end_run done");
  endtask : t_end_run

  task automatic t_timer_clear;
    cmd(SLP, 1'b1, lc(1'b1, 1'b0, TCHI_WRT_TM));
    wait_cyc(48);
    chk(dflag, 1'b0);
    @(posedge clk);
    track_sw <= 1'b1;
    wait_cyc(48);
    chk(dflag, 1'b1);
    @(posedge clk);
    track_sw <= 1'b0;
    wait_cyc(4);
    cmd(PCL, 1'b0, 18'h00000);
    chk({go, dflag, bflag, eflag, miss, wen, endst, trk, unab, mode, ek}, 18'h0);
    chk(unit, 4'h0);
    $display("test timer_clear done");
  endtask : t_timer_clear

  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    rst_n    = 1'b0;
    ev       = 4'h0;
    tape_in  = 18'h00000;
    track_sw = 1'b0;
    mkf      = 1'b0;
    tmf      = 1'b0;
    wall     = 1'b1;
    one_u    = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(2);
    t_reset();
    t_select_load();
    t_search();
    t_read_word();
    t_unable();
    t_end_run();
    t_timer_clear();
    complete_run();
  end

endmodule : tb_top
